// ---- hw/fsr_pkg.sv ----
// constants and status byte layouts for the flash status register read path
package fsr_pkg;

  // opcodes taken from the serial input
  localparam logic [7:0] FSR_OP_READ_LOW = 8'h05;
  localparam logic [7:0] FSR_OP_READ_HIGH = 8'h35;

  // bits that the write port may change in each byte
  localparam logic [7:0] FSR_WR_MASK_LOW = 8'hfc;
  localparam logic [7:0] FSR_WR_MASK_HIGH = 8'h7b;
  // page lock bits of the high byte, set-only
  localparam logic [7:0] FSR_LOCK_MASK = 8'h38;

  // reset values of the stored bits
  localparam logic [7:0] FSR_RST_LOW = 8'h00;
  localparam logic [7:0] FSR_RST_HIGH = 8'h00;

  // field positions
  localparam int FSR_BIT_MSB = 7;
  localparam int FSR_BIT_WEL = 1;
  localparam int FSR_BIT_BUSY = 0;
  localparam int FSR_BIT_SUSP = 7;
  localparam int FSR_BIT_RSVD = 2;

  // serial link timing
  localparam int FSR_REF_PERIOD_PS = 5000;
  localparam int FSR_LINK_PERIOD_NS = 80;
  localparam int FSR_LINK_CYCLES = (FSR_LINK_PERIOD_NS * 1000) / FSR_REF_PERIOD_PS;

  typedef struct packed {
    logic status_protect_sel_low;
    logic sector_size_sel;
    logic protect_top_bottom_sel;
    logic protect_level_b2;
    logic protect_level_b1;
    logic protect_level_b0;
    logic write_enable_latch;
    logic busy_flag;
  } fsr_status_low_s;

  typedef struct packed {
    logic erase_suspended_flag;
    logic protect_complement;
    logic page3_lock;
    logic page2_lock;
    logic page1_lock;
    logic reserved_bit;
    logic quad_io_enable;
    logic status_protect_sel_high;
  } fsr_status_high_s;

  typedef enum logic [1:0] {
    FSR_ST_OPCODE = 2'b00,
    FSR_ST_READ = 2'b01,
    FSR_ST_IGNORE = 2'b10
  } fsr_state_e;

endpackage

// ---- hw/fsr_status_read.sv ----
// flash status register store and serial status read engine
`timescale 1ns/10ps
module fsr_status_read
  import fsr_pkg::*;
(
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // serial pins
  input wire logic spi_sel_n_i,
  input wire logic spi_clk_i,
  input wire logic spi_si_i,
  output logic spi_so_o,
  output logic spi_so_oe_n_o,
  // live device state, same clock domain
  input wire logic write_enable_latch_i,
  input wire logic busy_flag_i,
  input wire logic erase_suspended_flag_i,
  // status write port, same clock domain
  input wire logic stat_wr_i,
  input wire logic stat_wr_high_i,
  input wire logic [7:0] stat_wr_data_i,
  // status images
  output fsr_status_low_s status_low_o,
  output fsr_status_high_s status_high_o
);

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  logic [2:0] sel_meta;
  logic [2:0] sel_sync;
  logic sync_clk_old;
  logic [2:0] next_sel_meta;
  logic [2:0] next_sel_sync;
  logic next_sync_clk_old;

  // only the second stage and sync_clk_old behind it are read by logic; the first may be metastable
  always_comb
  begin
    next_sel_meta = {spi_si_i, spi_clk_i, spi_sel_n_i};
    next_sel_sync = sel_meta;
    next_sync_clk_old = sel_sync[1];
  end

  // reset to pin idle levels (select high, clock low) so release shows no false edge
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      sel_meta <= 3'h1;
      sel_sync <= 3'h1;
      sync_clk_old <= 1'b0;
    end
    else
    begin
      sel_meta <= next_sel_meta;
      sel_sync <= next_sel_sync;
      sync_clk_old <= next_sync_clk_old;
    end
  end

  // sel_sync holds {si, sclk, sel_n} after two flops
  logic sel_n_s;
  logic sclk_s;
  logic si_s;
  logic sclk_rise;
  logic sclk_fall;

  assign sel_n_s = sel_sync[0];
  assign sclk_s = sel_sync[1];
  assign si_s = sel_sync[2];
  assign sclk_rise = sclk_s & ~sync_clk_old;
  assign sclk_fall = ~sclk_s & sync_clk_old;
  // limitation: sclk must stay below about a sixth of ref_clk_i for edges to be seen

  // ****************************************************************
  // status store
  // ****************************************************************
  logic [7:0] cfg_low;
  logic [7:0] cfg_high;
  logic [7:0] live_low;
  logic [7:0] live_high;
  logic [7:0] next_cfg_low;
  logic [7:0] next_cfg_high;
  logic [7:0] next_live_low;
  logic [7:0] next_live_high;

  always_comb
  begin
    next_cfg_low = cfg_low;
    next_cfg_high = cfg_high;
    if (stat_wr_i && !stat_wr_high_i)
    begin
      next_cfg_low = (cfg_low & ~FSR_WR_MASK_LOW) | (stat_wr_data_i & FSR_WR_MASK_LOW);
    end
    if (stat_wr_i && stat_wr_high_i)
    begin
      next_cfg_high = ((cfg_high & ~FSR_WR_MASK_HIGH) | (stat_wr_data_i & FSR_WR_MASK_HIGH))
                      | (cfg_high & FSR_LOCK_MASK);
    end
    // writable fields of each byte
    next_live_low = next_cfg_low & FSR_WR_MASK_LOW;
    next_live_low[FSR_BIT_WEL] = write_enable_latch_i;
    next_live_low[FSR_BIT_BUSY] = busy_flag_i;
    next_live_high = next_cfg_high & FSR_WR_MASK_HIGH;
    next_live_high[FSR_BIT_SUSP] = erase_suspended_flag_i;
    next_live_high[FSR_BIT_RSVD] = 1'b0;
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      cfg_low <= FSR_RST_LOW;
      cfg_high <= FSR_RST_HIGH;
      live_low <= FSR_RST_LOW;
      live_high <= FSR_RST_HIGH;
    end
    else
    begin
      cfg_low <= next_cfg_low;
      cfg_high <= next_cfg_high;
      live_low <= next_live_low;
      live_high <= next_live_high;
    end
  end

  assign status_low_o = fsr_status_low_s'(live_low);
  assign status_high_o = fsr_status_high_s'(live_high);

  // ****************************************************************
  // serial engine
  // ****************************************************************
  fsr_state_e state;
  fsr_state_e next_state;
  logic [7:0] op_shift;
  logic [7:0] next_op_shift;
  logic [2:0] op_cnt;
  logic [2:0] next_op_cnt;
  logic [2:0] bit_idx;
  logic [2:0] next_bit_idx;
  logic sel_high;
  logic next_sel_high;
  logic [7:0] snap;
  logic [7:0] next_snap;
  logic so_q;
  logic next_so;
  logic so_oe_n_q;
  logic next_so_oe_n;
  logic [7:0] live_sel;
  logic [7:0] op_word;

  always_comb
  begin
    next_state = state;
    next_op_shift = op_shift;
    next_op_cnt = op_cnt;
    next_bit_idx = bit_idx;
    next_sel_high = sel_high;
    next_snap = snap;
    next_so = so_q;
    next_so_oe_n = so_oe_n_q;
    live_sel = sel_high ? live_high : live_low;
    op_word = {op_shift[6:0], si_s};
    if (sel_n_s)
    begin
      // release may come at any bit; nothing is flagged
      next_state = FSR_ST_OPCODE;
      next_op_cnt = 3'h0;
      next_so_oe_n = 1'b1;
    end
    else
    begin
      unique case (state)
        FSR_ST_OPCODE:
        begin
          if (sclk_rise)
          begin
            next_op_shift = op_word;
            next_op_cnt = op_cnt + 3'h1;
            if (op_cnt == 3'h7)
            begin
              next_bit_idx = 3'(FSR_BIT_MSB);
              // busy state plays no part in accepting the read
              if (op_word == FSR_OP_READ_LOW)
              begin
                next_state = FSR_ST_READ;
                next_sel_high = 1'b0;
              end
              else if (op_word == FSR_OP_READ_HIGH)
              begin
                next_state = FSR_ST_READ;
                next_sel_high = 1'b1;
              end
              else
              begin
                next_state = FSR_ST_IGNORE;
              end
            end
          end
        end
        FSR_ST_READ:
        begin
          if (sclk_fall)
          begin
            next_so_oe_n = 1'b0;
            if (bit_idx == 3'(FSR_BIT_MSB))
            begin
              // fresh copy per pass so polling sees busy drop
              next_snap = live_sel;
              next_so = live_sel[FSR_BIT_MSB];
            end
            else
            begin
              next_so = snap[bit_idx];
            end
            next_bit_idx = bit_idx - 3'h1;
          end
        end
        FSR_ST_IGNORE:
        begin
          next_so_oe_n = 1'b1;
        end
        default:
        begin
          next_state = FSR_ST_OPCODE;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      state <= FSR_ST_OPCODE;
      op_shift <= 8'h00;
      op_cnt <= 3'h0;
      bit_idx <= 3'h7;
      sel_high <= 1'b0;
      snap <= 8'h00;
      so_q <= 1'b0;
      so_oe_n_q <= 1'b1;
    end
    else
    begin
      state <= next_state;
      op_shift <= next_op_shift;
      op_cnt <= next_op_cnt;
      bit_idx <= next_bit_idx;
      sel_high <= next_sel_high;
      snap <= next_snap;
      so_q <= next_so;
      so_oe_n_q <= next_so_oe_n;
    end
  end

  // ****************************************************************
  // pin drive
  // ****************************************************************
  // both straight from flops so the pin never glitches between bits
  assign spi_so_o = so_q;
  assign spi_so_oe_n_o = so_oe_n_q;

endmodule

// ---- verif/fsr_spi_host.sv ----
// spi host model for the status read block, mode 0, 80 ns clock
`timescale 1ns/10ps
module fsr_spi_host
(
  // serial pins
  output logic sel_n_o,
  output logic sclk_o,
  output logic si_o,
  input wire logic so_i,
  input wire logic so_oe_n_i
);
  // ****
  // frame
  // ****
  initial
  begin
    sel_n_o = 1'b1;
    sclk_o = 1'b0;
    si_o = 1'b0;
  end
  // si is toggled when unused so a stale level never reads as data
  task automatic frame(input logic [7:0] op, input int nbits, output logic [31:0] rx,
    output int drv);
    rx = '0;
    drv = 0;
    sel_n_o = 1'b0;
    for (int i = 7; i >= 0; i--)
    begin
      si_o = op[i];
      #40 sclk_o = 1'b1;
      #40 sclk_o = 1'b0;
    end
    for (int i = 0; i < nbits; i++)
    begin
      si_o = ~si_o;
      #40 sclk_o = 1'b1;
      // a released line floats: show the inverse of the stale level
      rx = {rx[30:0], so_oe_n_i ? ~so_i : so_i};
      drv += !so_oe_n_i;
      #40 sclk_o = 1'b0;
    end
    #40 sel_n_o = 1'b1;
    si_o = ~si_o;
  endtask
endmodule

// ---- verif/fsr_status_read_sva.sv ----
// port assertions for the status read block
`timescale 1ns/10ps
module fsr_status_read_sva
  import fsr_pkg::*;
(
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // serial pins
  input wire logic spi_sel_n_i,
  input wire logic spi_clk_i,
  input wire logic spi_si_i,
  input wire logic spi_so_o,
  input wire logic spi_so_oe_n_o,
  // live state and write port
  input wire logic write_enable_latch_i,
  input wire logic busy_flag_i,
  input wire logic erase_suspended_flag_i,
  input wire logic stat_wr_i,
  input wire logic stat_wr_high_i,
  input wire logic [7:0] stat_wr_data_i,
  // images
  input wire fsr_status_low_s status_low_o,
  input wire fsr_status_high_s status_high_o
);
  // ****
  // properties
  // ****
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  // images are zero one edge past release, so wait two
  property p_wel; $past(rst_n_i, 2) |-> status_low_o[1] == $past(write_enable_latch_i); endproperty
  a_wel: assert property (p_wel) else $error("wel image");
  property p_busy; $past(rst_n_i, 2) |-> status_low_o[0] == $past(busy_flag_i); endproperty
  a_busy: assert property (p_busy) else $error("busy image");
  property p_susp; $past(rst_n_i, 2) |-> status_high_o[7] == $past(erase_suspended_flag_i); endproperty
  a_susp: assert property (p_susp) else $error("suspend image");
  property p_rsv; status_high_o[2] == 1'b0; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bit");
  property p_lock; $past(rst_n_i) |-> &(status_high_o[5:3] | ~$past(status_high_o[5:3])); endproperty
  a_lock: assert property (p_lock) else $error("lock cleared");
  property p_wrlo; stat_wr_i && !stat_wr_high_i |=> status_low_o[7:2] == $past(stat_wr_data_i[7:2]);
  endproperty
  a_wrlo: assert property (p_wrlo) else $error("low write");
  property p_wrhi; stat_wr_i && stat_wr_high_i |=> (status_high_o & 8'h43) == ($past(stat_wr_data_i) & 8'h43);
  endproperty
  a_wrhi: assert property (p_wrhi) else $error("high write");
  property p_rel; spi_sel_n_i [*5] |-> spi_so_oe_n_o; endproperty
  a_rel: assert property (p_rel) else $error("output not released");
  property p_sel; !spi_so_oe_n_o |-> !$past(spi_sel_n_i, 4); endproperty
  a_sel: assert property (p_sel) else $error("driven unselected");
endmodule

// ---- verif/testbench.sv ----
// self-checking bench for the status read block
`timescale 1ns/10ps
module testbench
  import fsr_pkg::*;
;
  logic ref_clk_i, rst_n_i, spi_sel_n_i, spi_clk_i, spi_si_i, spi_so_o, spi_so_oe_n_o;
  logic write_enable_latch_i, busy_flag_i, erase_suspended_flag_i, stat_wr_i, stat_wr_high_i;
  logic [7:0] stat_wr_data_i;
  fsr_status_low_s status_low_o;
  fsr_status_high_s status_high_o;
  logic [31:0] rx;
  int drv;
  int num_errors = 0;
  int tests_run = 0;
  fsr_status_read dut_u (.ref_clk_i, .rst_n_i, .spi_sel_n_i, .spi_clk_i, .spi_si_i, .spi_so_o,
    .spi_so_oe_n_o, .write_enable_latch_i, .busy_flag_i, .erase_suspended_flag_i, .stat_wr_i,
    .stat_wr_high_i, .stat_wr_data_i, .status_low_o, .status_high_o);
  fsr_spi_host hst_u (.sel_n_o(spi_sel_n_i), .sclk_o(spi_clk_i), .si_o(spi_si_i),
    .so_i(spi_so_o), .so_oe_n_i(spi_so_oe_n_o));
  // ****
  // tasks
  // ****
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      num_errors++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic hi, input logic [7:0] d);
    stat_wr_i = 1'b1;
    stat_wr_high_i = hi;
    stat_wr_data_i = d;
    @(negedge ref_clk_i);
    stat_wr_i = 1'b0;
    repeat (2) @(negedge ref_clk_i);
  endtask
  task automatic t_write();
    busy_flag_i = 1'b0;
    wr_reg(1'b0, 8'ha5);
    check({24'h0, status_low_o}, 32'ha6);
    wr_reg(1'b1, 8'hff);
    check({24'h0, status_high_o}, 32'hfb);
    wr_reg(1'b1, 8'h00);
    check({24'h0, status_high_o}, 32'hb8);
  endtask
  // busy falls mid-frame, only the second pass may show it
  task automatic t_poll();
    busy_flag_i = 1'b1;
    fork
      hst_u.frame(FSR_OP_READ_LOW, 16, rx, drv);
      #1000 busy_flag_i = 1'b0;
    join
    check(rx, 32'ha7a6);
    check(drv, 16);
  endtask
  task automatic t_partial();
    repeat (4) @(negedge ref_clk_i);
    hst_u.frame(FSR_OP_READ_HIGH, 13, rx, drv);
    check(rx, 32'h1717);
    check(drv, 13);
    repeat (5) @(negedge ref_clk_i);
    check({31'h0, spi_so_oe_n_o}, 32'h1);
    hst_u.frame(8'h9f, 8, rx, drv);
    check(drv, 0);
  endtask
  task automatic results();
    if (num_errors == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // ****
  // sequence
  // ****
  initial
  begin
    ref_clk_i = 1'b0;
    forever #2.5 ref_clk_i = ~ref_clk_i;
  end
  initial
  begin
    #100000;
    num_errors++;
    results();
  end
  initial
  begin
    rst_n_i = 1'b0;
    write_enable_latch_i = 1'b1;
    busy_flag_i = 1'b1;
    erase_suspended_flag_i = 1'b1;
    stat_wr_i = 1'b0;
    stat_wr_high_i = 1'b0;
    stat_wr_data_i = 8'h00;
    repeat (6) @(negedge ref_clk_i);
    check({status_high_o, status_low_o}, 32'h0);
    check({31'h0, spi_so_oe_n_o}, 32'h1);
    rst_n_i = 1'b1;
    repeat (4) @(negedge ref_clk_i);
    t_write();
    t_poll();
    t_partial();
    results();
  end
endmodule
bind fsr_status_read fsr_status_read_sva chk_u (.ref_clk_i, .rst_n_i, .spi_sel_n_i, .spi_clk_i,
  .spi_si_i, .spi_so_o, .spi_so_oe_n_o, .write_enable_latch_i, .busy_flag_i,
  .erase_suspended_flag_i, .stat_wr_i, .stat_wr_high_i, .stat_wr_data_i, .status_low_o,
  .status_high_o);
